/* File: include/mss_defines.svh */
`ifndef MSS_DEFINES_SVH
`define MSS_DEFINES_SVH

// Segment table
`define MSS_SEG_N       15
`define MSS_SEG_FIRST   4'h1
`define MSS_SEG_LAST    4'hF
`define MSS_SEG_RST     4'h1

// Time base: one second of the system clock
`define MSS_SEC_NS      1000000000
`define MSS_CLK_NS      8
`define MSS_SEC_CYC     (`MSS_SEC_NS / `MSS_CLK_NS)

// Sequence mode codes
`define MSS_MODE_ONCE   3'h0
`define MSS_MODE_ONCE_P 3'h1
`define MSS_MODE_CYC    3'h2
`define MSS_MODE_CYC_P  3'h3
`define MSS_MODE_HOLD   3'h4

// Reset values
`define MSS_SEC_RST     16'h0000
`define MSS_PRE_RST     27'h0000000
`define MSS_FREQ_RST    16'h0000

`endif

/* File: include/mss_pkg.sv */
package mss_pkg;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_RUN,
    ST_PAUSE,
    ST_HOLD
  } mss_state_e;

  typedef enum logic [2:0] {
    SRC_INCH,
    SRC_EXT,
    SRC_INT,
    SRC_PID,
    SRC_TRI,
    SRC_WIND,
    SRC_PRESET
  } mss_src_e;

endpackage : mss_pkg

/* File: rtl/mss_sequencer.sv */
`timescale 1ns/100ps
`default_nettype none
`include "mss_defines.svh"

// How it works
// - No memory: stop restarts from segment one
// - Memory set: stop keeps position, start resumes; stop from hold still restarts from segment one
// - Power loss clears all retained state
// - Enable runs program, else preset source
// - Fixed source priority, inching highest
// - Modes: once, pausing once, cyclic, pausing cyclic
// - Mode four holds final segment frequency
// - Mode ignored while sequencer disabled
// - Pausing modes stop between segments
// - Fifteen segment frequencies, 0.01 steps
// - External code selects stored segment frequency
// - Fifteen durations, each segment its own
// - Segment n pairs frequency n, duration n
// - Direction word fixes each segment's rotation
// - Bit n: segment n, 1 reverse
// - Direction bits used only when enabled
module mss_sequencer #(
  parameter int unsigned SEC_CYCLES = `MSS_SEC_CYC
) (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 resume_memory_select,
  input  wire logic                 sequencer_enable,
  input  wire logic [2:0]           sequence_mode,
  input  wire logic [15:1][15:0]    segment_freq,
  input  wire logic [15:1][15:0]    segment_time,
  input  wire logic [15:0]          segment_direction_bits,
  input  wire logic [15:0]          preset_freq,
  input  wire logic                 pid_active,
  input  wire logic [15:0]          pid_freq,
  input  wire logic                 tri_active,
  input  wire logic [15:0]          tri_freq,
  input  wire logic                 wind_active,
  input  wire logic [15:0]          wind_freq,
  input  wire logic [15:0]          inching_freq,
  input  wire logic                 motor_stopped,
  input  wire logic                 run_pin,
  input  wire logic                 stop_pin,
  input  wire logic                 seq_start_pin,
  input  wire logic                 fault_pin,
  input  wire logic                 inching_pin,
  input  wire logic [3:0]           ext_speed_code,
  output logic [15:0]               freq_out,
  output logic                      dir_reverse,
  output mss_pkg::mss_src_e         source_sel,
  output logic [3:0]                seg_index,
  output logic                      seq_running
);

  // Pin synchroniser
  logic [8:0] pin_s1_ff;
  logic [8:0] pin_s2_ff;
  logic       run_prev_ff;
  logic       start_prev_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_s1_ff     <= 9'h000;
      pin_s2_ff     <= 9'h000;
      run_prev_ff   <= 1'b0;
      start_prev_ff <= 1'b0;
    end else begin
      pin_s1_ff     <= {run_pin, stop_pin, seq_start_pin, fault_pin,
                        inching_pin, ext_speed_code};
      pin_s2_ff     <= pin_s1_ff;
      run_prev_ff   <= pin_s2_ff[8];
      start_prev_ff <= pin_s2_ff[6];
    end
  end

  logic       stop_ev;
  logic       start_ev;
  logic       inch_s;
  logic [3:0] code_s;
  assign inch_s   = pin_s2_ff[4];
  assign code_s   = pin_s2_ff[3:0];
  assign stop_ev  = pin_s2_ff[7] | pin_s2_ff[5];
  assign start_ev = ((pin_s2_ff[8] & ~run_prev_ff) |
                     (pin_s2_ff[6] & ~start_prev_ff)) & ~stop_ev;

  // Sequence state
  mss_pkg::mss_state_e state_ff, nxt_state;
  logic [3:0]  seg_ff, nxt_seg;
  logic [15:0] sec_ff, nxt_sec;
  logic [26:0] pre_ff, nxt_pre;
  logic        run_ff, nxt_run;

  logic        tick;
  logic        seg_end;
  logic        last_seg;
  logic        mode_pause;
  logic        mode_cyc;
  logic        mode_hold;

  assign tick     = (pre_ff == 27'(SEC_CYCLES - 1));
  assign seg_end  = (sec_ff >= segment_time[seg_ff]);
  assign last_seg = (seg_ff == `MSS_SEG_LAST);
  assign nxt_run  = (nxt_state != mss_pkg::ST_IDLE);

  // Illegal codes above four behave as a single pass
  always_comb begin
    mode_pause = 1'b0;
    mode_cyc   = 1'b0;
    mode_hold  = 1'b0;
    unique case (sequence_mode)
      `MSS_MODE_ONCE_P: mode_pause = 1'b1;
      `MSS_MODE_CYC:    mode_cyc   = 1'b1;
      `MSS_MODE_CYC_P: begin
        mode_cyc   = 1'b1;
        mode_pause = 1'b1;
      end
      `MSS_MODE_HOLD:   mode_hold  = 1'b1;
      default: begin
      end
    endcase
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_seg   = seg_ff;
    nxt_sec   = sec_ff;
    nxt_pre   = pre_ff;
    if (!sequencer_enable) begin
      nxt_state = mss_pkg::ST_IDLE;
      nxt_seg   = `MSS_SEG_RST;
      nxt_sec   = `MSS_SEC_RST;
      nxt_pre   = `MSS_PRE_RST;
    end else begin
      unique case (state_ff)
        mss_pkg::ST_IDLE: begin
          if (start_ev) begin
            nxt_state = mss_pkg::ST_RUN;
            nxt_pre   = `MSS_PRE_RST;
          end
        end
        mss_pkg::ST_RUN: begin
          if (stop_ev) begin
            nxt_state = mss_pkg::ST_IDLE;
            if (!resume_memory_select) begin
              nxt_seg = `MSS_SEG_RST;
              nxt_sec = `MSS_SEC_RST;
            end
          end else if (seg_end) begin
            nxt_sec = `MSS_SEC_RST;
            nxt_pre = `MSS_PRE_RST;
            if (!last_seg) begin
              nxt_seg = seg_ff + 4'h1;
              if (mode_pause) begin
                nxt_state = mss_pkg::ST_PAUSE;
              end
            end else if (mode_cyc) begin
              nxt_seg = `MSS_SEG_FIRST;
              if (mode_pause) begin
                nxt_state = mss_pkg::ST_PAUSE;
              end
            end else if (mode_hold) begin
              nxt_state = mss_pkg::ST_HOLD;
            end else begin
              nxt_state = mss_pkg::ST_IDLE;
              nxt_seg   = `MSS_SEG_RST;
            end
          end else if (tick) begin
            nxt_pre = `MSS_PRE_RST;
            nxt_sec = sec_ff + 16'h0001;
          end else begin
            nxt_pre = pre_ff + 27'h0000001;
          end
        end
        mss_pkg::ST_PAUSE: begin
          if (stop_ev) begin
            nxt_state = mss_pkg::ST_IDLE;
            if (!resume_memory_select) begin
              nxt_seg = `MSS_SEG_RST;
            end
          end else if (motor_stopped) begin
            nxt_state = mss_pkg::ST_RUN;
          end
        end
        mss_pkg::ST_HOLD: begin
          // Pass is complete, nothing left to resume
          if (stop_ev) begin
            nxt_state = mss_pkg::ST_IDLE;
            nxt_seg   = `MSS_SEG_RST;
          end
        end
      endcase
    end
  end

  // Power-on reset leaves no retained position
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= mss_pkg::ST_IDLE;
      seg_ff   <= `MSS_SEG_RST;
      sec_ff   <= `MSS_SEC_RST;
      pre_ff   <= `MSS_PRE_RST;
      run_ff   <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      seg_ff   <= nxt_seg;
      sec_ff   <= nxt_sec;
      pre_ff   <= nxt_pre;
      run_ff   <= nxt_run;
    end
  end

  // Frequency source arbitration
  logic              seq_act;
  logic [15:0]       nxt_freq;
  logic              nxt_dir;
  mss_pkg::mss_src_e nxt_src;
  logic [15:0]       freq_ff;
  logic              dir_ff;
  mss_pkg::mss_src_e src_ff;

  assign seq_act = (state_ff != mss_pkg::ST_IDLE);

  always_comb begin
    nxt_src  = mss_pkg::SRC_PRESET;
    nxt_freq = preset_freq;
    nxt_dir  = 1'b0;
    if (sequencer_enable) begin
      nxt_dir = segment_direction_bits[0];
      if (inch_s) begin
        nxt_src  = mss_pkg::SRC_INCH;
        nxt_freq = inching_freq;
      end else if (code_s != 4'h0) begin
        nxt_src  = mss_pkg::SRC_EXT;
        nxt_freq = segment_freq[code_s];
        nxt_dir  = segment_direction_bits[code_s];
      end else if (seq_act) begin
        nxt_src  = mss_pkg::SRC_INT;
        nxt_freq = (state_ff == mss_pkg::ST_PAUSE) ? `MSS_FREQ_RST
                                                    : segment_freq[seg_ff];
        nxt_dir  = segment_direction_bits[seg_ff];
      end else if (pid_active) begin
        nxt_src  = mss_pkg::SRC_PID;
        nxt_freq = pid_freq;
      end else if (tri_active) begin
        nxt_src  = mss_pkg::SRC_TRI;
        nxt_freq = tri_freq;
      end else if (wind_active) begin
        nxt_src  = mss_pkg::SRC_WIND;
        nxt_freq = wind_freq;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      freq_ff <= `MSS_FREQ_RST;
      dir_ff  <= 1'b0;
      src_ff  <= mss_pkg::SRC_PRESET;
    end else begin
      freq_ff <= nxt_freq;
      dir_ff  <= nxt_dir;
      src_ff  <= nxt_src;
    end
  end

  assign freq_out    = freq_ff;
  assign dir_reverse = dir_ff;
  assign source_sel  = src_ff;
  assign seg_index   = seg_ff;
  assign seq_running = run_ff;

  // Checks
  sequence run_stop_s;
    sequencer_enable && state_ff == mss_pkg::ST_RUN && stop_ev;
  endsequence

  sequence last_end_s;
    sequencer_enable && state_ff == mss_pkg::ST_RUN && !stop_ev &&
    last_seg && seg_end;
  endsequence

  mem_clear_a: assert property (@(posedge clk) disable iff (rst)
    run_stop_s ##0 !resume_memory_select |=>
    seg_ff == `MSS_SEG_FIRST && sec_ff == `MSS_SEC_RST)
    else $error("position kept without memory");

  mem_keep_a: assert property (@(posedge clk) disable iff (rst)
    run_stop_s ##0 resume_memory_select |=>
    $stable(seg_ff) && $stable(sec_ff) && state_ff == mss_pkg::ST_IDLE)
    else $error("position lost with memory");

  reset_seg_a: assert property (@(posedge clk) disable iff (rst)
    $past(rst) |-> seg_ff == `MSS_SEG_FIRST && state_ff == mss_pkg::ST_IDLE)
    else $error("state survived reset");

  dis_source_a: assert property (@(posedge clk) disable iff (rst)
    !sequencer_enable |=> src_ff == mss_pkg::SRC_PRESET &&
    freq_ff == $past(preset_freq) && !dir_ff)
    else $error("disabled not on preset");

  inch_prio_a: assert property (@(posedge clk) disable iff (rst)
    sequencer_enable && inch_s |=> src_ff == mss_pkg::SRC_INCH &&
    freq_ff == $past(inching_freq))
    else $error("inching lost priority");

  once_stop_a: assert property (@(posedge clk) disable iff (rst)
    last_end_s ##0 sequence_mode == `MSS_MODE_ONCE |=>
    state_ff == mss_pkg::ST_IDLE && seg_ff == `MSS_SEG_FIRST)
    else $error("single pass did not stop");

  hold_last_a: assert property (@(posedge clk) disable iff (rst)
    last_end_s ##0 mode_hold |=> state_ff == mss_pkg::ST_HOLD ##1
    (!$past(sequencer_enable) || $past(inch_s) || $past(code_s) != 4'h0 ||
    freq_ff == $past(segment_freq[15])))
    else $error("hold mode left last frequency");

  pause_wait_a: assert property (@(posedge clk) disable iff (rst)
    sequencer_enable && state_ff == mss_pkg::ST_PAUSE && !stop_ev &&
    !motor_stopped |=> state_ff == mss_pkg::ST_PAUSE)
    else $error("pause left before motor stopped");

  seg_dir_a: assert property (@(posedge clk) disable iff (rst)
    sequencer_enable && !inch_s && code_s == 4'h0 && seq_act |=>
    dir_ff == $past(segment_direction_bits[seg_ff]) &&
    src_ff == mss_pkg::SRC_INT)
    else $error("segment direction wrong");

  sec_count_a: assert property (@(posedge clk) disable iff (rst)
    sequencer_enable && state_ff == mss_pkg::ST_RUN && !stop_ev &&
    !seg_end && tick |=> sec_ff == $past(sec_ff) + 16'h0001)
    else $error("second count did not advance");

endmodule : mss_sequencer
`default_nettype wire

/* File: tb/mss_motor_model.sv */
`timescale 1ns/100ps
`default_nettype none
module mss_motor_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [15:0] freq_cmd,
  input  wire logic        slow,
  output logic             motor_stopped
);
  logic [3:0] ramp_ff;
  // A real drive needs time to ramp down; slow stretches it
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      ramp_ff <= 4'h0;
    else if (freq_cmd != 16'h0000)
      ramp_ff <= slow ? 4'hC : 4'h2;
    else if (ramp_ff != 4'h0)
      ramp_ff <= ramp_ff - 4'h1;
  end
  assign motor_stopped = (freq_cmd == 16'h0000) && (ramp_ff == 4'h0);
endmodule : mss_motor_model
`default_nettype wire

/* File: tb/mss_sequencer_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module mss_sequencer_tb;
  logic              clk, rst, mem, en, runp, stopp, sp, fltp, inch, pa, ta, wa, dr, run, ms, slow;
  logic [2:0]        mode;
  logic [15:1][15:0] sf, st;
  logic [15:0]       dirb, pre, inf, aux, fo;
  logic [3:0]        code, si;
  mss_pkg::mss_src_e src;
  int                miscompares, checks, cyc;

  mss_sequencer #(.SEC_CYCLES(8)) mss_sequencer_inst (
    .clk(clk), .rst(rst), .resume_memory_select(mem), .sequencer_enable(en),
    .sequence_mode(mode), .segment_freq(sf), .segment_time(st), .segment_direction_bits(dirb),
    .preset_freq(pre), .pid_active(pa), .pid_freq(aux), .tri_active(ta), .tri_freq(aux),
    .wind_active(wa), .wind_freq(aux), .inching_freq(inf), .motor_stopped(ms), .run_pin(runp),
    .stop_pin(stopp), .seq_start_pin(sp), .fault_pin(fltp), .inching_pin(inch),
    .ext_speed_code(code), .freq_out(fo), .dir_reverse(dr), .source_sel(src), .seg_index(si),
    .seq_running(run));
  mss_motor_model mss_motor_model_inst (
    .clk(clk), .rst(rst), .freq_cmd(fo), .slow(slow), .motor_stopped(ms));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      results();
    end
  end

  task automatic results;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : results

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Each segment also spends one edge handing over to the next
  function automatic logic [15:0] seg_cycles(input logic [15:0] secs);
    return 16'(8 * secs + 1);
  endfunction : seg_cycles

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick

  task automatic wseg(input logic [3:0] n);
    int k;
    k = 0;
    while (si !== n && k < 99) begin
      tick(1);
      k++;
    end
  endtask : wseg

  task automatic start(input logic alt);
    if (alt)
      sp = 1'b1;
    else
      runp = 1'b1;
    tick(4);
    sp = 1'b0;
    runp = 1'b0;
    tick(1);
  endtask : start

  task automatic halt(input logic flt);
    if (flt)
      fltp = 1'b1;
    else
      stopp = 1'b1;
    tick(4);
    fltp = 1'b0;
    stopp = 1'b0;
    tick(1);
  endtask : halt

  task automatic pass_chk(input logic [2:0] m);
    int k;
    mode = m;
    start(1'b0);
    for (int n = 1; n <= 15; n++) begin
      wseg(4'(n));
      chk("seg", 16'(n), 16'(si));
      tick(2);
      chk("freq", sf[n], fo);
      chk("dir", 16'(dirb[n]), 16'(dr));
      // Segment one was entered two edges before start returned
      k = (n == 1) ? 4 : 2;
      while (si === 4'(n) && k < 40) begin
        tick(1);
        k++;
      end
      if (n < 15 || m != 3'h4)
        chk("time", seg_cycles(st[n]), 16'(k));
    end
    $display("test pass %0d done", m);
  endtask : pass_chk

  task automatic pause_chk(input logic [2:0] m);
    int k;
    mode = m;
    start(1'b0);
    k = 0;
    while (fo !== 16'h0000 && k < 99) begin
      tick(1);
      k++;
    end
    chk("freq", 16'h0000, fo);
    k = 0;
    while (fo !== sf[2] && k < 99) begin
      tick(1);
      k++;
    end
    chk("freq", sf[2], fo);
    chk("seg", 16'h0002, 16'(si));
    halt(1'b0);
    $display("test pause %0d done", m);
  endtask : pause_chk

  initial begin
    rst = 1'b1;
    {mem, en, runp, stopp, sp, fltp, inch, pa, ta, wa, slow} = 11'h000;
    mode = 3'h0;
    code = 4'h0;
    void'($urandom(10));
    for (int i = 1; i <= 15; i++) begin
      sf[i] = 16'(i * 256 + $urandom_range(255, 1));
      st[i] = 16'($urandom_range(2, 1));
    end
    dirb = 16'($urandom);
    pre = 16'($urandom);
    inf = 16'($urandom);
    aux = 16'($urandom);
    repeat (4) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    chk("src", 16'(mss_pkg::SRC_PRESET), 16'(src));
    chk("seg", 16'h0001, 16'(si));
    mode = 3'h4;
    start(1'b0);
    chk("run", 16'h0000, 16'(run));
    chk("freq", pre, fo);
    chk("dir", 16'h0000, 16'(dr));
    en = 1'b1;
    {pa, ta, wa} = 3'h7;
    tick(3);
    chk("src", 16'(mss_pkg::SRC_PID), 16'(src));
    pa = 1'b0;
    tick(3);
    chk("src", 16'(mss_pkg::SRC_TRI), 16'(src));
    ta = 1'b0;
    tick(3);
    chk("src", 16'(mss_pkg::SRC_WIND), 16'(src));
    chk("freq", aux, fo);
    wa = 1'b0;
    tick(3);
    chk("dir", 16'(dirb[0]), 16'(dr));
    code = 4'($urandom_range(15, 1));
    tick(4);
    chk("src", 16'(mss_pkg::SRC_EXT), 16'(src));
    chk("freq", sf[code], fo);
    inch = 1'b1;
    tick(4);
    chk("src", 16'(mss_pkg::SRC_INCH), 16'(src));
    chk("freq", inf, fo);
    {inch, code} = 5'h00;
    tick(4);
    $display("test priority done");
    pass_chk(3'h0);
    chk("run", 16'h0000, 16'(run));
    pass_chk(3'h2);
    chk("run", 16'h0001, 16'(run));
    halt(1'b0);
    pass_chk(3'h4);
    chk("freq", sf[15], fo);
    halt(1'b0);
    slow = 1'b1;
    pause_chk(3'h1);
    pause_chk(3'h3);
    slow = 1'b0;
    mem = 1'b1;
    start(1'b1);
    wseg(4'h3);
    // Let the pause end so the fault lands while segment three runs
    tick(6);
    halt(1'b1);
    chk("seg", 16'h0003, 16'(si));
    start(1'b1);
    chk("seg", 16'h0003, 16'(si));
    chk("run", 16'h0001, 16'(run));
    mem = 1'b0;
    halt(1'b1);
    chk("seg", 16'h0001, 16'(si));
    mem = 1'b1;
    start(1'b0);
    wseg(4'h2);
    rst = 1'b1;
    tick(1);
    rst = 1'b0;
    chk("seg", 16'h0001, 16'(si));
    chk("run", 16'h0000, 16'(run));
    $display("test memory done");
    results();
  end
endmodule : mss_sequencer_tb
`default_nettype wire
